// file: src/adc_resolution_offset_shift_control.sv
// converter resolution, offset shift and full measurement sequencer
// assumes configuration words held stable by the configuration memory
//
// Function
// - sensor conversion resolution comes from the resolution field, 12 to 18 bits.
// - single conversion lasts 140/185/250/335/470/640/890 us for 12..18 bits.
// - offset shift active only when config bit 15 is one.
// - offset shift level selected by config bits 14 to 12.
// - shift enabled gives converter gain two, otherwise gain one.
// - levels 0..7 compensate 0 to 43.25 percent of input offset.
// - end-of-conversion falls at measurement start, rises at its end.
// - full measurement lasts 2.2 ms at 12 bits to 3.7 ms at 18.
// - full measurement runs four conversions, temperature ones at 16 bits.
// - two configuration words share one bit layout and decode.
`timescale 1ns/10ps
`include "adc_ctrl_cfg.svh"

module adc_resolution_offset_shift_control #(
  parameter int unsigned CNT_W = `CNT_WIDTH,
  parameter int unsigned CONV_CYC [`RES_CODES] = '{
    `CONV_TIME_12_US * `REF_CLK_MHZ, `CONV_TIME_13_US * `REF_CLK_MHZ,
    `CONV_TIME_14_US * `REF_CLK_MHZ, `CONV_TIME_15_US * `REF_CLK_MHZ,
    `CONV_TIME_16_US * `REF_CLK_MHZ, `CONV_TIME_17_US * `REF_CLK_MHZ,
    `CONV_TIME_18_US * `REF_CLK_MHZ},
  parameter int unsigned FULL_CYC [`RES_CODES] = '{
    int'(`FULL_TIME_12_MS * `US_PER_MS * `REF_CLK_MHZ),
    int'(`FULL_TIME_13_MS * `US_PER_MS * `REF_CLK_MHZ),
    int'(`FULL_TIME_14_MS * `US_PER_MS * `REF_CLK_MHZ),
    int'(`FULL_TIME_15_MS * `US_PER_MS * `REF_CLK_MHZ),
    int'(`FULL_TIME_16_MS * `US_PER_MS * `REF_CLK_MHZ),
    int'(`FULL_TIME_17_MS * `US_PER_MS * `REF_CLK_MHZ),
    int'(`FULL_TIME_18_MS * `US_PER_MS * `REF_CLK_MHZ)}
) (
  // clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 resetn,
  // configuration words and selection
  input  wire logic [`CFG_W-1:0]    sensor_meas_config_first,
  input  wire logic [`CFG_W-1:0]    sensor_meas_config_second,
  input  wire logic                 config_second_sel,
  // measurement request
  input  wire logic                 full_command_a,
  // measurement status
  output logic                      eoc_q,
  output logic                      conv_done_q,
  output adc_ctrl_pkg::phase_e      phase_q,
  output logic [4:0]                adc_resolution_q,
  // analog setup
  output logic                      gain_two_q,
  output logic [2:0]                offset_level_q,
  output logic [12:0]               offset_comp_q,
  output logic                      setup_error_q
);

  // ***************************************************************
  // elaboration checks
  // ***************************************************************
  for (genvar i = 0; i < `RES_CODES; i++)
  begin : g_check
    if (FULL_CYC[i] <= 2 * CONV_CYC[i] + 2 * CONV_CYC[`RES_TEMP_IDX] + 1)
    begin : g_short
      $error("full measurement shorter than its conversions");
    end
    if (FULL_CYC[i] >= (64'd1 << CNT_W) || CONV_CYC[i] < 1)
    begin : g_wide
      $error("cycle count does not fit the counter");
    end
  end

  // ***************************************************************
  // configuration decode
  // ***************************************************************
  function automatic logic [2:0] cfg_res_idx(input logic [`CFG_W-1:0] w);
    logic [2:0] r;
    r = w[`CFG_RES_MSB:`CFG_RES_LSB];
    // unused code 7 runs at 18 bits
    return (r > 3'(`RES_MAX_IDX)) ? 3'(`RES_MAX_IDX) : r;
  endfunction : cfg_res_idx

  function automatic logic cfg_shift(input logic [`CFG_W-1:0] w);
    return w[`CFG_SHIFT_BIT];
  endfunction : cfg_shift

  function automatic logic [2:0] cfg_level(input logic [`CFG_W-1:0] w);
    return w[`CFG_LEVEL_MSB:`CFG_LEVEL_LSB];
  endfunction : cfg_level

  function automatic logic [12:0] level_comp(input logic [2:0] l);
    logic [12:0] c;
    c = `OFFS_COMP_0;
    unique case (l)
      3'h0: c = `OFFS_COMP_0;
      3'h1: c = `OFFS_COMP_1;
      3'h2: c = `OFFS_COMP_2;
      3'h3: c = `OFFS_COMP_3;
      3'h4: c = `OFFS_COMP_4;
      3'h5: c = `OFFS_COMP_5;
      3'h6: c = `OFFS_COMP_6;
      3'h7: c = `OFFS_COMP_7;
    endcase
    return c;
  endfunction : level_comp

  function automatic logic [CNT_W-1:0] to_cnt(input int unsigned c);
    return CNT_W'(c - 1);
  endfunction : to_cnt

  // both words decode through the same functions
  wire logic [2:0] res_first    = cfg_res_idx(sensor_meas_config_first);
  wire logic [2:0] res_second   = cfg_res_idx(sensor_meas_config_second);
  wire logic       shift_first  = cfg_shift(sensor_meas_config_first);
  wire logic       shift_second = cfg_shift(sensor_meas_config_second);
  wire logic [2:0] lvl_first    = cfg_level(sensor_meas_config_first);
  wire logic [2:0] lvl_second   = cfg_level(sensor_meas_config_second);

  wire logic [2:0] res_sel   = config_second_sel ? res_second   : res_first;
  wire logic       shift_sel = config_second_sel ? shift_second : shift_first;
  wire logic [2:0] lvl_sel   = config_second_sel ? lvl_second   : lvl_first;

  // ***************************************************************
  // sequencer
  // ***************************************************************
  logic [CNT_W-1:0]     cnt_q;
  logic [CNT_W-1:0]     cnt_d;
  logic [2:0]           res_idx_q;
  adc_ctrl_pkg::phase_e phase_d;

  wire logic start    = full_command_a && (phase_q == adc_ctrl_pkg::PH_IDLE);
  wire logic cnt_zero = (cnt_q == '0);
  wire logic in_conv  = (phase_q != adc_ctrl_pkg::PH_IDLE) && (phase_q != adc_ctrl_pkg::PH_CALC);
  wire logic conv_end = in_conv && cnt_zero;
  wire logic meas_end = (phase_q == adc_ctrl_pkg::PH_CALC) && cnt_zero;

  // processing time fills the full measurement after four conversions
  wire logic [31:0] calc_cyc = FULL_CYC[res_idx_q] - 2 * CONV_CYC[res_idx_q]
                               - 2 * CONV_CYC[`RES_TEMP_IDX];

  always_comb
  begin
    phase_d = phase_q;
    cnt_d   = cnt_q - CNT_W'(1);
    unique case (phase_q)
      adc_ctrl_pkg::PH_IDLE:
      begin
        cnt_d = cnt_q;
        if (start)
        begin
          phase_d = adc_ctrl_pkg::PH_SENSOR_AUTOZERO;
          cnt_d   = to_cnt(CONV_CYC[res_sel]);
        end
      end
      adc_ctrl_pkg::PH_SENSOR_AUTOZERO:
        if (cnt_zero)
        begin
          phase_d = adc_ctrl_pkg::PH_SENSOR;
          cnt_d   = to_cnt(CONV_CYC[res_idx_q]);
        end
      adc_ctrl_pkg::PH_SENSOR:
        if (cnt_zero)
        begin
          phase_d = adc_ctrl_pkg::PH_TEMP_AUTOZERO;
          cnt_d   = to_cnt(CONV_CYC[`RES_TEMP_IDX]);
        end
      adc_ctrl_pkg::PH_TEMP_AUTOZERO:
        if (cnt_zero)
        begin
          phase_d = adc_ctrl_pkg::PH_TEMP;
          cnt_d   = to_cnt(CONV_CYC[`RES_TEMP_IDX]);
        end
      adc_ctrl_pkg::PH_TEMP:
        if (cnt_zero)
        begin
          phase_d = adc_ctrl_pkg::PH_CALC;
          cnt_d   = to_cnt(calc_cyc);
        end
      adc_ctrl_pkg::PH_CALC:
        if (cnt_zero)
        begin
          phase_d = adc_ctrl_pkg::PH_IDLE;
          cnt_d   = '0;
        end
    endcase
  end

  // resolution of the conversion now running
  wire logic [2:0] act_idx_d = (phase_d == adc_ctrl_pkg::PH_TEMP_AUTOZERO
                                || phase_d == adc_ctrl_pkg::PH_TEMP)
                               ? 3'(`RES_TEMP_IDX)
                               : (start ? res_sel : res_idx_q);
  wire logic [4:0] res_bits_d = 5'(`RES_MIN_BITS) + {2'h0, act_idx_d};

  // ***************************************************************
  // registers
  // ***************************************************************
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      phase_q   <= adc_ctrl_pkg::PH_IDLE;
      cnt_q     <= '0;
      res_idx_q <= `RES_IDX_RST;
    end
    else
    begin
      phase_q   <= phase_d;
      cnt_q     <= cnt_d;
      res_idx_q <= start ? res_sel : res_idx_q;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      eoc_q            <= 1'b1;
      conv_done_q      <= 1'b0;
      adc_resolution_q <= 5'(`RES_MIN_BITS);
    end
    else
    begin
      eoc_q            <= start ? 1'b0 : (meas_end ? 1'b1 : eoc_q);
      conv_done_q      <= conv_end;
      adc_resolution_q <= res_bits_d;
    end
  end

  // gain, offset level and compensation latched for the whole measurement; setup_error_q follows the selected word every cycle
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      gain_two_q     <= 1'b0;
      offset_level_q <= `LEVEL_RST;
      offset_comp_q  <= `OFFS_COMP_0;
      setup_error_q  <= 1'b0;
    end
    else
    begin
      if (start)
      begin
        gain_two_q     <= shift_sel;
        offset_level_q <= shift_sel ? lvl_sel : `LEVEL_RST;
        offset_comp_q  <= shift_sel ? level_comp(lvl_sel) : `OFFS_COMP_0;
      end
      setup_error_q <= !shift_sel && (lvl_sel != `LEVEL_RST);
    end
  end

endmodule : adc_resolution_offset_shift_control

// file: src/adc_ctrl_cfg.svh
// constants for the converter resolution / offset shift control
// assumes a 200 MHz ref_clk and 16-bit measurement configuration words
`ifndef ADC_CTRL_CFG_SVH
`define ADC_CTRL_CFG_SVH

// clock rate
`define REF_CLK_MHZ        200

// configuration word fields
`define CFG_W              16
`define CFG_SHIFT_BIT      15
`define CFG_LEVEL_MSB      14
`define CFG_LEVEL_LSB      12
`define CFG_RES_MSB        9
`define CFG_RES_LSB        7

// resolutions
`define RES_MIN_BITS       12
`define RES_MAX_IDX        6
`define RES_TEMP_IDX       4
`define RES_CODES          7

// single conversion times, microseconds
`define CONV_TIME_12_US    140
`define CONV_TIME_13_US    185
`define CONV_TIME_14_US    250
`define CONV_TIME_15_US    335
`define CONV_TIME_16_US    470
`define CONV_TIME_17_US    640
`define CONV_TIME_18_US    890

// full measurement times, milliseconds
`define FULL_TIME_12_MS    2.2
`define FULL_TIME_13_MS    2.3
`define FULL_TIME_14_MS    2.4
`define FULL_TIME_15_MS    2.6
`define FULL_TIME_16_MS    2.8
`define FULL_TIME_17_MS    3.2
`define FULL_TIME_18_MS    3.7
`define US_PER_MS          1000.0

// cycle counter width
`define CNT_WIDTH          20

// offset compensation, hundredths of a percent
`define OFFS_COMP_0        13'h0000
`define OFFS_COMP_1        13'h02A3
`define OFFS_COMP_2        13'h04E2
`define OFFS_COMP_3        13'h0785
`define OFFS_COMP_4        13'h09C4
`define OFFS_COMP_5        13'h0C67
`define OFFS_COMP_6        13'h0F0A
`define OFFS_COMP_7        13'h10E5

// reset values
`define LEVEL_RST          3'h0
`define RES_IDX_RST        3'h0

`endif

// file: src/adc_ctrl_pkg.sv
// types for the converter resolution / offset shift control
// assumes adc_ctrl_cfg.svh supplies the numeric constants
package adc_ctrl_pkg;

  // measurement sequence phase
  typedef enum logic [2:0] {
    PH_IDLE,
    PH_SENSOR_AUTOZERO,
    PH_SENSOR,
    PH_TEMP_AUTOZERO,
    PH_TEMP,
    PH_CALC
  } phase_e;

endpackage : adc_ctrl_pkg

// file: test/adc_ctrl_sva.sv
// assertions for the resolution / offset shift control
// assumes bind onto the control block's top ports
`timescale 1ns/10ps
`include "adc_ctrl_cfg.svh"
module adc_ctrl_sva #(
  parameter int unsigned CNT_W = 20,
  parameter int unsigned CONV_CYC [`RES_CODES] = '{default: 1},
  parameter int unsigned FULL_CYC [`RES_CODES] = '{default: 1}
) (
  // clock, reset, inputs
  input wire logic                 ref_clk,
  input wire logic                 resetn,
  input wire logic [`CFG_W-1:0]    sensor_meas_config_first,
  input wire logic [`CFG_W-1:0]    sensor_meas_config_second,
  input wire logic                 config_second_sel,
  input wire logic                 full_command_a,
  // outputs
  input wire logic                 eoc_q,
  input wire logic                 conv_done_q,
  input wire adc_ctrl_pkg::phase_e phase_q,
  input wire logic [4:0]           adc_resolution_q,
  input wire logic                 gain_two_q,
  input wire logic [2:0]           offset_level_q,
  input wire logic [12:0]          offset_comp_q
);
  // ****
  // helper state
  // ****
  localparam logic [12:0] COMP [8] = '{`OFFS_COMP_0, `OFFS_COMP_1, `OFFS_COMP_2, `OFFS_COMP_3,
                                       `OFFS_COMP_4, `OFFS_COMP_5, `OFFS_COMP_6, `OFFS_COMP_7};
  wire logic [`CFG_W-1:0] cfg  = config_second_sel ? sensor_meas_config_second : sensor_meas_config_first;
  wire logic [2:0]        idx  = (cfg[9:7] == 3'h7) ? 3'h6 : cfg[9:7];
  wire logic              idle = phase_q == adc_ctrl_pkg::PH_IDLE;
  wire logic              own  = phase_q == adc_ctrl_pkg::PH_SENSOR || phase_q == adc_ctrl_pkg::PH_TEMP_AUTOZERO;
  logic [2:0]             idx_q;
  logic [CNT_W-1:0]       low_q;
  logic [CNT_W-1:0]       ph_cnt_q;
  adc_ctrl_pkg::phase_e   ph_prev_q;
  always_ff @(posedge ref_clk or negedge resetn)
    if (!resetn)
    begin
      idx_q     <= 3'h0;
      low_q     <= '0;
      ph_cnt_q  <= '0;
      ph_prev_q <= adc_ctrl_pkg::PH_IDLE;
    end
    else
    begin
      if (full_command_a && idle) idx_q <= idx;
      low_q     <= eoc_q ? '0 : low_q + 1'b1;
      ph_cnt_q  <= (phase_q != ph_prev_q) ? CNT_W'(1) : ph_cnt_q + 1'b1;
      ph_prev_q <= phase_q;
    end
  // ****
  // properties
  // ****
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  sequence s_start;
    full_command_a && idle;
  endsequence
  property p_eoc_fall;
    s_start |=> !eoc_q && phase_q == adc_ctrl_pkg::PH_SENSOR_AUTOZERO;
  endproperty
  a_eoc_fall: assert property (p_eoc_fall) else $error("eoc not low after start");
  property p_gain;
    s_start |=> gain_two_q == $past(cfg[15]);
  endproperty
  a_gain: assert property (p_gain) else $error("gain does not follow shift bit");
  property p_level;
    s_start |=> offset_level_q == ($past(cfg[15]) ? $past(cfg[14:12]) : 3'h0);
  endproperty
  a_level: assert property (p_level) else $error("offset level wrong");
  property p_comp;
    !eoc_q |-> offset_comp_q == COMP[offset_level_q];
  endproperty
  a_comp: assert property (p_comp) else $error("compensation wrong for level");
  property p_res;
    s_start |=> adc_resolution_q == 5'h0c + 5'($past(idx));
  endproperty
  a_res: assert property (p_res) else $error("resolution wrong at start");
  property p_temp_res;
    phase_q inside {adc_ctrl_pkg::PH_TEMP_AUTOZERO, adc_ctrl_pkg::PH_TEMP} |-> adc_resolution_q == 5'h10;
  endproperty
  a_temp_res: assert property (p_temp_res) else $error("temperature not at 16 bits");
  property p_full;
    $rose(eoc_q) |-> low_q == CNT_W'(FULL_CYC[idx_q]);
  endproperty
  a_full: assert property (p_full) else $error("eoc low time wrong");
  property p_conv;
    conv_done_q |-> ph_cnt_q == CNT_W'(own ? CONV_CYC[idx_q] : CONV_CYC[`RES_TEMP_IDX]);
  endproperty
  a_conv: assert property (p_conv) else $error("conversion length wrong");
endmodule : adc_ctrl_sva

bind adc_resolution_offset_shift_control adc_ctrl_sva #(.CNT_W(CNT_W), .CONV_CYC(CONV_CYC), .FULL_CYC(FULL_CYC))
  i_adc_ctrl_sva (.ref_clk(ref_clk), .resetn(resetn), .sensor_meas_config_first(sensor_meas_config_first),
  .sensor_meas_config_second(sensor_meas_config_second), .config_second_sel(config_second_sel),
  .full_command_a(full_command_a), .eoc_q(eoc_q), .conv_done_q(conv_done_q), .phase_q(phase_q),
  .adc_resolution_q(adc_resolution_q), .gain_two_q(gain_two_q), .offset_level_q(offset_level_q),
  .offset_comp_q(offset_comp_q));

// file: test/cfg_memory_model.sv
// configuration memory and host watching end-of-conversion
// assumes the bench loads words between measurements
`timescale 1ns/10ps
module cfg_memory_model (
  // clock and bench load
  input wire logic        ref_clk,
  input wire logic        load,
  input wire logic        slot,
  input wire logic        allow_bad,
  input wire logic [15:0] word_in,
  // words to the block
  output logic [15:0]     first_q = 16'h0000,
  output logic [15:0]     second_q = 16'h0000,
  // host side
  input wire logic        eoc_q,
  output int unsigned     low_q = 0
);
  logic             eoc_prev_q = 1'b1;
  // shift off forces level zero unless told to misbehave
  wire logic [15:0] word_ok = (word_in[15] || allow_bad) ? word_in : {4'h0, word_in[11:0]};
  always_ff @(posedge ref_clk)
  begin
    if (load && !slot) first_q <= word_ok;
    if (load && slot) second_q <= word_ok;
    eoc_prev_q <= eoc_q;
    if (!eoc_q) low_q <= eoc_prev_q ? 1 : low_q + 1;
  end
endmodule : cfg_memory_model

// file: test/tb.sv
// self-checking bench for the resolution / offset shift control
// assumes short conversion counts handed in as parameters
`timescale 1ns/10ps
`include "adc_ctrl_cfg.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin failures++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (b)); end end
module tb;
  // ****
  // bench state
  // ****
  localparam int unsigned CONV [7] = '{10, 11, 12, 13, 14, 15, 16};
  localparam int unsigned FULL [7] = '{80, 90, 100, 110, 120, 130, 140};
  localparam logic [12:0] COMP [8] = '{`OFFS_COMP_0, `OFFS_COMP_1, `OFFS_COMP_2, `OFFS_COMP_3,
                                       `OFFS_COMP_4, `OFFS_COMP_5, `OFFS_COMP_6, `OFFS_COMP_7};
  logic ref_clk = 0, resetn = 0, sel = 0, cmd = 0, load = 0, slot = 0, bad = 0;
  logic [15:0] word_in = 16'h0000, first_w, second_w;
  logic eoc_q, conv_done_q, gain_two_q, setup_error_q;
  adc_ctrl_pkg::phase_e phase_q;
  logic [4:0] adc_resolution_q;
  logic [2:0] offset_level_q;
  logic [12:0] offset_comp_q;
  int unsigned low_q;
  int failures = 0, tests_run = 0;
  integer seed = 32'hb667;
  initial forever #2.5 ref_clk = ~ref_clk;
  adc_resolution_offset_shift_control #(.CONV_CYC(CONV), .FULL_CYC(FULL)) i_adc_resolution_offset_shift_control (
    .ref_clk(ref_clk), .resetn(resetn), .sensor_meas_config_first(first_w), .sensor_meas_config_second(second_w),
    .config_second_sel(sel), .full_command_a(cmd), .eoc_q(eoc_q), .conv_done_q(conv_done_q), .phase_q(phase_q),
    .adc_resolution_q(adc_resolution_q), .gain_two_q(gain_two_q), .offset_level_q(offset_level_q),
    .offset_comp_q(offset_comp_q), .setup_error_q(setup_error_q));
  cfg_memory_model i_cfg_memory_model (.ref_clk(ref_clk), .load(load), .slot(slot), .allow_bad(bad),
    .word_in(word_in), .first_q(first_w), .second_q(second_w), .eoc_q(eoc_q), .low_q(low_q));
  function automatic logic [2:0] exp_idx(input logic [2:0] code);
    return (code == 3'h7) ? 3'h6 : code;
  endfunction : exp_idx
  task wrap_up;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up
  // ****
  // one full measurement
  // ****
  task automatic run_meas(input logic [2:0] code, input logic sh, input logic [2:0] lv, input logic s,
                          input logic b, input logic hold);
    logic [2:0] ix;
    logic [2:0] elv;
    int pulses, n_s, n_t;
    ix = exp_idx(code);
    elv = sh ? lv : 3'h0;
    pulses = 0;
    n_s = 0;
    n_t = 0;
    @(posedge ref_clk) #1;
    load = 1;
    slot = s;
    bad = b;
    sel = s;
    word_in = {sh, lv, 2'($random(seed)), code, 7'($random(seed))};
    @(posedge ref_clk) #1 load = 0;
    @(posedge ref_clk) #1 cmd = 1;
    `CHK(setup_error_q, b && !sh && lv != 3'h0)
    @(posedge ref_clk) #1 cmd = hold;
    `CHK(eoc_q, 1'b0)
    `CHK(gain_two_q, sh)
    `CHK(offset_level_q, elv)
    `CHK(offset_comp_q, COMP[elv])
    `CHK(adc_resolution_q, 5'h0c + 5'(ix))
    for (int n = 0; n < 1000 && eoc_q !== 1'b1; n++)
    begin
      @(posedge ref_clk) #1;
      pulses += int'(conv_done_q === 1'b1);
      n_s += int'(phase_q === adc_ctrl_pkg::PH_SENSOR);
      n_t += int'(phase_q === adc_ctrl_pkg::PH_TEMP && adc_resolution_q === 5'h10);
    end
    cmd = 0;
    if (eoc_q !== 1'b1)
    begin
      failures++;
      wrap_up;
    end
    `CHK(low_q, FULL[ix])
    `CHK(pulses, 4)
    `CHK(n_s, CONV[ix])
    `CHK(n_t, CONV[4])
    $display("test done code %0d shift %0d level %0d", code, sh, lv);
  endtask : run_meas
  // ****
  // reset while a measurement runs
  // ****
  task automatic reset_mid;
    @(posedge ref_clk) #1 cmd = 1;
    @(posedge ref_clk) #1 cmd = 0;
    `CHK(eoc_q, 1'b0)
    repeat (20) @(posedge ref_clk);
    #1 resetn = 0;
    #1;
    `CHK(eoc_q, 1'b1)
    `CHK(conv_done_q, 1'b0)
    `CHK(gain_two_q, 1'b0)
    `CHK(offset_comp_q, `OFFS_COMP_0)
    `CHK(adc_resolution_q, 5'h0c)
    @(posedge ref_clk) #1 resetn = 1;
    $display("test done reset in flight");
  endtask : reset_mid
  // ****
  // main sequence
  // ****
  initial
  begin
    repeat (6) @(posedge ref_clk);
    #1 resetn = 1;
    `CHK(eoc_q, 1'b1)
    for (int c = 0; c < 8; c++) run_meas(3'(c), 1'b1, 3'(c), c[0], 1'b0, c == 3);
    reset_mid;
    run_meas(3'h0, 1'b0, 3'h5, 1'b0, 1'b0, 1'b0);
    run_meas(3'h2, 1'b0, 3'h6, 1'b1, 1'b1, 1'b0);
    for (int r = 0; r < 6; r++)
      run_meas(3'($random(seed)), 1'($random(seed)), 3'($random(seed)), 1'($random(seed)), 1'b0, 1'b0);
    wrap_up;
  end
endmodule : tb
